// ==== hdl/tla_alarm_defines.svh ====
`ifndef TLA_ALARM_DEFINES_SVH
`define TLA_ALARM_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (read and write addresses differ for some)
// ---------------------------------------------------------------
`define TLA_A_LOC_RES     8'h00
`define TLA_A_REM_RES_HI  8'h01
`define TLA_A_STATUS      8'h02
`define TLA_A_CFG_RD      8'h03
`define TLA_A_RATE_RD     8'h04
`define TLA_A_LHI_RD      8'h05
`define TLA_A_LLO_RD      8'h06
`define TLA_A_RHI_RD      8'h07
`define TLA_A_RLO_RD      8'h08
`define TLA_A_CFG_WR      8'h09
`define TLA_A_RATE_WR     8'h0A
`define TLA_A_LHI_WR      8'h0B
`define TLA_A_LLO_WR      8'h0C
`define TLA_A_RHI_WR      8'h0D
`define TLA_A_RLO_WR      8'h0E
`define TLA_A_ONESHOT     8'h0F
`define TLA_A_REM_RES_LO  8'h10
`define TLA_A_OFF_HI      8'h11
`define TLA_A_OFF_LO      8'h12
`define TLA_A_RHI_LO      8'h13
`define TLA_A_RLO_LO      8'h14
`define TLA_A_RFAN        8'h19
`define TLA_A_LFAN        8'h20
`define TLA_A_HYST        8'h21
`define TLA_A_FILT        8'h22
`define TLA_A_MAKER       8'hFE

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TLA_R_ZERO        8'h00
`define TLA_R_RATE        8'h08
`define TLA_R_HI_LIM      8'h55
`define TLA_R_FAN_LIM     8'h6C
`define TLA_R_HYST        8'h0A
`define TLA_R_FILT        8'h01

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TLA_CFG_MASK      7
`define TLA_CFG_STBY      6
`define TLA_CFG_PIN       5
`define TLA_CFG_RANGE     2
`define TLA_FILT_TMO      7
`define TLA_FILT_LSB      1
`define TLA_FILT_MSB      3

// ---------------------------------------------------------------
// clamp limits of the corrected remote result, quarter degrees
// ---------------------------------------------------------------
`define TLA_REM_MAX_BIN   12'h1FF
`define TLA_REM_MAX_EXT   12'h3FF

`endif

// ==== hdl/tla_pkg.sv ====
`default_nettype none

package tla_pkg;

   // byte from the serial engine: first byte of a write is the pointer
   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } tla_wr_s;

   // one finished conversion from the converter
   typedef struct packed {
      logic       done;
      logic [7:0] locTemp;
      logic [9:0] remTemp;
      logic       sensorOpen;
   } tla_meas_s;

   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] cfg;
      logic [7:0] rate;
      logic [7:0] locHi;
      logic [7:0] locLo;
      logic [7:0] remHiM;
      logic [7:0] remLoM;
      logic [1:0] remHiL;
      logic [1:0] remLoL;
      logic [7:0] offM;
      logic [1:0] offL;
      logic [7:0] remFan;
      logic [7:0] locFan;
      logic [7:0] hyst;
      logic [7:0] filt;
      logic [7:0] locRes;
      logic [9:0] remRes;
      logic       openNow;
      logic [4:0] sticky;
      logic       alertLatch;
      logic [7:0] rdData;
      logic       oneShot;
      logic       sample;
   } tla_main_s;

   typedef struct packed {
      logic [2:0] count;
   } tla_cmp_s;

   typedef struct packed {
      logic trip;
   } tla_hyst_s;

endpackage : tla_pkg

`default_nettype wire

// ==== hdl/tla_limit_cmp.sv ====
`default_nettype none

module tla_limit_cmp
   import tla_pkg::*;
#(
   parameter int W = 10
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         sample,
   input  wire logic [W-1:0] temp,
   input  wire logic [W-1:0] hiLim,
   input  wire logic [W-1:0] loLim,
   input  wire logic [2:0]   need,
   output logic              overNow,
   output logic              underNow,
   output logic              overFilt,
   output logic              underFilt
);

   tla_cmp_s r_reg;
   tla_cmp_s r_next;
   logic     enough;

   assign overNow   = temp > hiLim;
   assign underNow  = temp <= loLim;
   assign enough    = r_reg.count >= need;
   assign overFilt  = overNow & enough;
   assign underFilt = underNow & enough;

   always_comb begin
      r_next = r_reg;
      if (sample) begin
         if (!(overNow | underNow)) begin
            r_next.count = 3'h0;
         end else if (r_reg.count != 3'h4) begin
            r_next.count = r_reg.count + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   filtCount_a: assert property (@(posedge clk) disable iff (sys_rst)
      sample && (overNow || underNow) && r_reg.count != 3'h4 |=> r_reg.count == $past(r_reg.count) + 3'h1)
      else $error("fault run count not advanced");

   runReset_a: assert property (@(posedge clk) disable iff (sys_rst)
      sample && !overNow && !underNow |=> r_reg.count == 3'h0)
      else $error("fault run not restarted");

endmodule : tla_limit_cmp

`default_nettype wire

// ==== hdl/tla_fan_hyst.sv ====
`default_nettype none

module tla_fan_hyst
   import tla_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] temp,
   input  wire logic [7:0] limit,
   input  wire logic [7:0] hyst,
   output logic            trip
);

   tla_hyst_s  r_reg;
   tla_hyst_s  r_next;
   logic [7:0] release_lvl;

   // saturate so a large hysteresis cannot wrap the release level
   assign release_lvl = (hyst > limit) ? 8'h00 : limit - hyst;
   assign trip        = r_reg.trip;

   always_comb begin
      r_next = r_reg;
      if (temp > limit) begin
         r_next.trip = 1'b1;
      end else if (temp <= release_lvl) begin
         r_next.trip = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   bandHold_a: assert property (@(posedge clk) disable iff (sys_rst)
      r_reg.trip && temp > release_lvl |=> r_reg.trip)
      else $error("fan trip released inside hysteresis band");

   tripSet_a: assert property (@(posedge clk) disable iff (sys_rst)
      temp > limit |=> r_reg.trip)
      else $error("fan trip not set above limit");

endmodule : tla_fan_hyst

`default_nettype wire

// ==== hdl/tla_alarm_top.sv ====
`include "tla_alarm_defines.svh"
`default_nettype none

module tla_alarm_top
   import tla_pkg::*;
#(
   // arbitrary neutral value
   parameter logic [7:0] MAKER_CODE = 8'h5A
) (
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire tla_wr_s   wr,
   input  wire logic      rdStrobe,
   input  wire logic      araStrobe,
   input  wire tla_meas_s meas,
   input  wire logic      convBusy,
   output logic [7:0]     rdData,
   output logic           oneShotReq,
   output logic           standbyMode,
   output logic           extRange,
   output logic [7:0]     rateCode,
   output logic           busTimeoutEn,
   output logic           fan_limit_out_n,
   output logic           fanLimitOe,
   output logic           alarmOut,
   output logic           alarmOe
);

   tla_main_s   r_reg;
   tla_main_s   r_next;

   logic        alertMode;
   logic        statusRd;
   logic [9:0]  offset;
   logic [11:0] remSum;
   logic [9:0]  remAdj;
   logic [2:0]  need;
   logic [4:0]  setVec;
   logic [4:0]  condVec;
   logic [4:0]  keepVec;
   logic [7:0]  statusByte;
   logic        lOverNow;
   logic        lUnderNow;
   logic        lOverF;
   logic        lUnderF;
   logic        rOverNow;
   logic        rUnderNow;
   logic        rOverF;
   logic        rUnderF;
   logic        lFanTrip;
   logic        rFanTrip;
   logic        lHiTrip;
   logic        rHiTrip;

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   // pin role select
   assign alertMode    = ~r_reg.cfg[`TLA_CFG_PIN];
   assign standbyMode  = r_reg.cfg[`TLA_CFG_STBY];
   assign extRange     = r_reg.cfg[`TLA_CFG_RANGE];
   assign rateCode     = r_reg.rate;
   assign busTimeoutEn = r_reg.filt[`TLA_FILT_TMO];
   assign statusRd     = rdStrobe & (r_reg.ptr == `TLA_A_STATUS);

   always_comb begin
      need = 3'h1;
      for (int i = `TLA_FILT_LSB; i <= `TLA_FILT_MSB; i++) begin
         need = need + {2'b00, r_reg.filt[i]};
      end
   end

   // ---------------------------------------------------------------
   // remote offset correction
   // ---------------------------------------------------------------
   // signed offset add
   assign offset = {r_reg.offM, r_reg.offL};
   assign remSum = $signed({2'b00, meas.remTemp}) + $signed({{2{offset[9]}}, offset});

   always_comb begin
      if (remSum[11]) begin
         remAdj = 10'h000;
      end else if (!extRange && remSum > `TLA_REM_MAX_BIN) begin
         remAdj = 10'(`TLA_REM_MAX_BIN);
      end else if (remSum > `TLA_REM_MAX_EXT) begin
         remAdj = 10'(`TLA_REM_MAX_EXT);
      end else begin
         remAdj = remSum[9:0];
      end
   end

   // ---------------------------------------------------------------
   // limit comparators
   // ---------------------------------------------------------------
   // compared in stored format
   tla_limit_cmp #(.W(8)) u_locCmp (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .sample    (r_reg.sample),
      .temp      (r_reg.locRes),
      .hiLim     (r_reg.locHi),
      .loLim     (r_reg.locLo),
      .need      (need),
      .overNow   (lOverNow),
      .underNow  (lUnderNow),
      .overFilt  (lOverF),
      .underFilt (lUnderF)
   );

   tla_limit_cmp #(.W(10)) u_remCmp (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .sample    (r_reg.sample),
      .temp      (r_reg.remRes),
      .hiLim     ({r_reg.remHiM, r_reg.remHiL}),
      .loLim     ({r_reg.remLoM, r_reg.remLoL}),
      .need      (need),
      .overNow   (rOverNow),
      .underNow  (rUnderNow),
      .overFilt  (rOverF),
      .underFilt (rUnderF)
   );

   // ---------------------------------------------------------------
   // fan limit channels, shared hysteresis
   // ---------------------------------------------------------------
   // one hysteresis for all
   tla_fan_hyst u_locFan (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (r_reg.locRes),
      .limit   (r_reg.locFan),
      .hyst    (r_reg.hyst),
      .trip    (lFanTrip)
   );

   tla_fan_hyst u_remFan (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (r_reg.remRes[9:2]),
      .limit   (r_reg.remFan),
      .hyst    (r_reg.hyst),
      .trip    (rFanTrip)
   );

   // second pin behaves like the fan pin, so it reuses the hysteresis
   tla_fan_hyst u_locHi (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (r_reg.locRes),
      .limit   (r_reg.locHi),
      .hyst    (r_reg.hyst),
      .trip    (lHiTrip)
   );

   tla_fan_hyst u_remHi (
      .clk     (clk),
      .sys_rst (sys_rst),
      .temp    (r_reg.remRes[9:2]),
      .limit   (r_reg.remHiM),
      .hyst    (r_reg.hyst),
      .trip    (rHiTrip)
   );

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   assign setVec  = {lOverF, lUnderF, rOverF, rUnderF, r_reg.openNow};
   assign condVec = {lOverNow, lUnderNow, rOverNow, rUnderNow, r_reg.openNow};
   assign keepVec = statusRd ? condVec : 5'h1F;

   assign statusByte = {convBusy, r_reg.sticky, rFanTrip, lFanTrip};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      r_next         = r_reg;
      r_next.oneShot = 1'b0;
      r_next.sample  = 1'b0;

      if (meas.done) begin
         r_next.locRes  = meas.locTemp;
         r_next.remRes  = remAdj;
         r_next.openNow = meas.sensorOpen;
         r_next.sample  = 1'b1;
      end

      if (wr.valid) begin
         if (wr.first) begin
            r_next.ptr = wr.data;
         end else begin
            case (r_reg.ptr)
               `TLA_A_CFG_WR: r_next.cfg = wr.data & 8'hE4;
               `TLA_A_RATE_WR: r_next.rate = wr.data;
               `TLA_A_LHI_WR: r_next.locHi = wr.data;
               `TLA_A_LLO_WR: r_next.locLo = wr.data;
               `TLA_A_RHI_WR: r_next.remHiM = wr.data;
               `TLA_A_RLO_WR: r_next.remLoM = wr.data;
               `TLA_A_ONESHOT: r_next.oneShot = standbyMode;
               `TLA_A_OFF_HI: r_next.offM = wr.data;
               `TLA_A_OFF_LO: r_next.offL = wr.data[7:6];
               `TLA_A_RHI_LO: r_next.remHiL = wr.data[7:6];
               `TLA_A_RLO_LO: r_next.remLoL = wr.data[7:6];
               `TLA_A_RFAN: r_next.remFan = wr.data;
               `TLA_A_LFAN: r_next.locFan = wr.data;
               `TLA_A_HYST: r_next.hyst = wr.data;
               `TLA_A_FILT: r_next.filt = wr.data;
               default: r_next.ptr = r_reg.ptr;
            endcase
         end
      end

      // set wins over a read clear in the same cycle
      if (alertMode) begin
         r_next.sticky = setVec | (r_reg.sticky & keepVec);
      end else begin
         r_next.sticky[4:1] = setVec[4:1];
         r_next.sticky[0]   = setVec[0] | (r_reg.sticky[0] & keepVec[0]);
      end

      r_next.alertLatch = (alertMode & (|r_reg.sticky))
                        | (r_reg.alertLatch & ~(araStrobe & (r_reg.sticky == 5'h00)));

      case (r_reg.ptr)
         `TLA_A_LOC_RES: r_next.rdData = r_reg.locRes;
         `TLA_A_REM_RES_HI: r_next.rdData = r_reg.remRes[9:2];
         `TLA_A_STATUS: r_next.rdData = statusByte;
         `TLA_A_CFG_RD: r_next.rdData = r_reg.cfg;
         `TLA_A_RATE_RD: r_next.rdData = r_reg.rate;
         `TLA_A_LHI_RD: r_next.rdData = r_reg.locHi;
         `TLA_A_LLO_RD: r_next.rdData = r_reg.locLo;
         `TLA_A_RHI_RD: r_next.rdData = r_reg.remHiM;
         `TLA_A_RLO_RD: r_next.rdData = r_reg.remLoM;
         `TLA_A_REM_RES_LO: r_next.rdData = {r_reg.remRes[1:0], 6'h00};
         `TLA_A_OFF_HI: r_next.rdData = r_reg.offM;
         `TLA_A_OFF_LO: r_next.rdData = {r_reg.offL, 6'h00};
         `TLA_A_RHI_LO: r_next.rdData = {r_reg.remHiL, 6'h00};
         `TLA_A_RLO_LO: r_next.rdData = {r_reg.remLoL, 6'h00};
         `TLA_A_RFAN: r_next.rdData = r_reg.remFan;
         `TLA_A_LFAN: r_next.rdData = r_reg.locFan;
         `TLA_A_HYST: r_next.rdData = r_reg.hyst;
         `TLA_A_FILT: r_next.rdData = r_reg.filt;
         `TLA_A_MAKER: r_next.rdData = MAKER_CODE;
         default: r_next.rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg        <= '0;
         r_reg.rate   <= `TLA_R_RATE;
         r_reg.locHi  <= `TLA_R_HI_LIM;
         r_reg.remHiM <= `TLA_R_HI_LIM;
         r_reg.remFan <= `TLA_R_FAN_LIM;
         r_reg.locFan <= `TLA_R_FAN_LIM;
         r_reg.hyst   <= `TLA_R_HYST;
         r_reg.filt   <= `TLA_R_FILT;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   assign rdData          = r_reg.rdData;
   assign oneShotReq      = r_reg.oneShot;
   assign fanLimitOe      = lFanTrip | rFanTrip;
   assign fan_limit_out_n = ~fanLimitOe;
   assign alarmOe  = alertMode ? (r_reg.alertLatch & ~r_reg.cfg[`TLA_CFG_MASK]) : (lHiTrip | rHiTrip);
   assign alarmOut = ~alarmOe;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence oneShotWrite;
      wr.valid && !wr.first && r_reg.ptr == `TLA_A_ONESHOT && standbyMode;
   endsequence

   sequence oneShotPulse;
      oneShotReq ##1 !oneShotReq;
   endsequence

   oneShot_pulse_a: assert property (oneShotWrite |=> oneShotPulse)
      else $error("one-shot write gave no single pulse");

   pointer_load_a: assert property (wr.valid && wr.first |=> r_reg.ptr == $past(wr.data))
      else $error("pointer not loaded from first byte");

   flag_hold_a: assert property (alertMode && r_reg.sticky[4] && lOverNow |=> r_reg.sticky[4])
      else $error("local high flag dropped while fault persists");

   read_clear_a: assert property (
      alertMode && statusRd && r_reg.sticky[4] && !lOverNow |=> !r_reg.sticky[4])
      else $error("status read did not clear a gone flag");

   latch_set_a: assert property (alertMode && (|r_reg.sticky) |=> r_reg.alertLatch)
      else $error("alarm latch not set by flag");

   latch_keep_a: assert property (r_reg.alertLatch && !araStrobe |=> r_reg.alertLatch)
      else $error("alarm latch cleared without service");

   mask_pin_a: assert property (alertMode && r_reg.cfg[`TLA_CFG_MASK] |-> !alarmOe)
      else $error("masked alarm pin still driven");

   second_pin_a: assert property (!alertMode |-> alarmOe == (lHiTrip || rHiTrip))
      else $error("second pin not following high trips");

   busy_bit_a: assert property (r_reg.ptr == `TLA_A_STATUS && !wr.valid |=> rdData[7] == $past(convBusy))
      else $error("busy bit does not follow converter");

   fan_pin_a: assert property (lFanTrip || rFanTrip |-> !fan_limit_out_n)
      else $error("fan pin not low on trip");

endmodule : tla_alarm_top

`default_nettype wire

// ==== verif/tla_host_model.sv ====
`default_nettype none

module tla_host_model
   import tla_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdData,
   output var  tla_wr_s    wr,
   output var  logic       rdStrobe,
   output var  logic       araStrobe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      wr = '0;
      rdStrobe = 1'b0;
      araStrobe = 1'b0;
   end

   // ----
   // byte transfers
   // ----
   // released data shows the inverse so a stale byte never looks valid
   task automatic put(input logic first, input logic [7:0] d);
      @(negedge clk);
      wr <= '{1'b1, first, d};
      @(negedge clk);
      wr <= '{1'b0, 1'b0, ~d};
   endtask : put

   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      put(1'b1, a);
      put(1'b0, d);
   endtask : wrReg

   task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
      put(1'b1, a);
      @(negedge clk);
      d = rdData;
      rdStrobe <= 1'b1;
      @(negedge clk);
      rdStrobe <= 1'b0;
   endtask : rdReg

   task automatic service();
      @(negedge clk);
      araStrobe <= 1'b1;
      @(negedge clk);
      araStrobe <= 1'b0;
   endtask : service

endmodule : tla_host_model

`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none

module tb
   import tla_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk = 1'b0;
   logic       sysRst = 1'b1;
   logic       convBusy = 1'b0;
   tla_meas_s  meas = '{1'b0, 8'h30, 10'h0C0, 1'b0};
   tla_wr_s    wr;
   logic       rdStrobe, araStrobe, oneShotReq, standbyMode, fanN, fanOe, alarmOe;
   logic [7:0] rdData, v, rateCode;
   logic       extRange, busTimeoutEn, alarmOut;
   int         mismatches = 0;
   int         samplesChecked = 0;
   localparam logic [7:0] RA [8] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22};
   localparam logic [7:0] RV [8] = '{8'h00, 8'h08, 8'h55, 8'h55, 8'h6C, 8'h6C, 8'h0A, 8'h01};

   always #2.5 clk = ~clk;

   tla_alarm_top i_tla_alarm_top (
      .clk(clk), .sys_rst(sysRst), .wr(wr), .rdStrobe(rdStrobe), .araStrobe(araStrobe),
      .meas(meas), .convBusy(convBusy), .rdData(rdData), .oneShotReq(oneShotReq),
      .standbyMode(standbyMode), .extRange(extRange), .rateCode(rateCode), .busTimeoutEn(busTimeoutEn),
      .fan_limit_out_n(fanN), .fanLimitOe(fanOe), .alarmOut(alarmOut), .alarmOe(alarmOe));

   tla_host_model i_tla_host_model (
      .clk(clk), .rdData(rdData), .wr(wr), .rdStrobe(rdStrobe), .araStrobe(araStrobe));

   // ----
   // helpers
   // ----
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a);
      i_tla_host_model.rdReg(a, v);
   endtask : rd

   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      i_tla_host_model.wrReg(a, d);
   endtask : wrt

   task automatic rst();
      @(negedge clk);
      sysRst = 1'b1;
      repeat (4) @(negedge clk);
      sysRst = 1'b0;
   endtask : rst

   // flags and latch settle within four edges of a result
   task automatic conv(input logic [7:0] l, input logic [9:0] r);
      @(negedge clk);
      meas <= '{1'b1, l, r, 1'b0};
      @(negedge clk);
      meas.done <= 1'b0;
      repeat (6) @(negedge clk);
   endtask : conv

   task automatic oneShot(input logic [7:0] cfg, input logic exp);
      logic seen;
      seen = 1'b0;
      wrt(8'h09, cfg);
      wrt(8'h0F, 8'hAB);
      for (int k = 0; k < 4; k++) begin
         if (oneShotReq === 1'b1) seen = 1'b1;
         @(negedge clk);
      end
      chk("one shot", {7'h00, seen}, {7'h00, exp});
   endtask : oneShot

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      rst();
      foreach (RA[i]) begin
         rd(RA[i]);
         chk("reset value", v, RV[i]);
      end
      wrt(8'h09, 8'h04);
      chk("range out", {7'h00, extRange}, 8'h01);
      wrt(8'h0A, 8'h05);
      chk("rate out", rateCode, 8'h05);
      rd(8'h05);
      chk("limit after range", v, 8'h55);
      $display("test reset done");
      rst();
      wrt(8'h0B, 8'h50);
      rd(8'h05);
      chk("local high", v, 8'h50);
      conv(8'h50, 10'h0C0);
      chk("alarm at limit", {7'h00, alarmOe}, 8'h00);
      conv(8'h51, 10'h0C0);
      rd(8'h02);
      chk("status over", v, 8'h40);
      chk("alarm over", {6'h00, alarmOut, alarmOe}, 8'h01);
      rd(8'h02);
      chk("status held", v, 8'h40);
      conv(8'h30, 10'h0C0);
      rd(8'h02);
      rd(8'h02);
      chk("status cleared", v, 8'h00);
      chk("latch kept", {7'h00, alarmOe}, 8'h01);
      i_tla_host_model.service();
      repeat (2) @(negedge clk);
      chk("latch serviced", {6'h00, alarmOut, alarmOe}, 8'h02);
      $display("test limits done");
      rst();
      wrt(8'h0E, 8'h30);
      wrt(8'h14, 8'h40);
      conv(8'h30, 10'h0C2);
      rd(8'h02);
      chk("remote above low", v, 8'h00);
      conv(8'h30, 10'h0C1);
      rd(8'h02);
      chk("remote at low", v, 8'h08);
      $display("test remote low done");
      rst();
      conv(8'h6D, 10'h0C0);
      chk("fan trip", {6'h00, fanN, fanOe}, 8'h01);
      rd(8'h02);
      chk("fan flag", v & 8'h01, 8'h01);
      conv(8'h63, 10'h0C0);
      chk("fan hyst", {6'h00, fanN, fanOe}, 8'h01);
      conv(8'h62, 10'h0C0);
      chk("fan release", {6'h00, fanN, fanOe}, 8'h02);
      rd(8'h02);
      chk("fan flag auto", v & 8'h01, 8'h00);
      $display("test fan done");
      rst();
      wrt(8'h22, 8'h82);
      chk("timeout bit", {7'h00, busTimeoutEn}, 8'h01);
      conv(8'h60, 10'h0C0);
      conv(8'h30, 10'h0C0);
      conv(8'h60, 10'h0C0);
      rd(8'h02);
      chk("broken run", v, 8'h00);
      conv(8'h60, 10'h0C0);
      rd(8'h02);
      chk("two in a row", v, 8'h40);
      $display("test filter done");
      rst();
      wrt(8'h11, 8'h02);
      wrt(8'h12, 8'h40);
      conv(8'h30, 10'h0C0);
      rd(8'h01);
      chk("offset upper", v, 8'h32);
      rd(8'h10);
      chk("offset lower", v, 8'h40);
      wrt(8'h11, 8'h80);
      conv(8'h30, 10'h0C0);
      rd(8'h01);
      chk("offset clamp low", v, 8'h00);
      wrt(8'h11, 8'h7F);
      conv(8'h30, 10'h0C0);
      rd(8'h01);
      chk("offset clamp high", v, 8'h7F);
      wrt(8'h09, 8'h04);
      conv(8'h30, 10'h0C0);
      rd(8'h01);
      chk("offset extended", v, 8'hAF);
      $display("test offset done");
      rst();
      wrt(8'h09, 8'hA0);
      wrt(8'h0C, 8'h20);
      conv(8'h56, 10'h0C0);
      chk("second pin over", {7'h00, alarmOe}, 8'h01);
      conv(8'h10, 10'h0C0);
      chk("second pin low", {7'h00, alarmOe}, 8'h00);
      meas <= '{1'b1, 8'h30, 10'h0C0, 1'b1};
      conv(8'h30, 10'h0C0);
      rd(8'h02);
      chk("open sticky", v, 8'h04);
      rd(8'h02);
      chk("open read clear", v, 8'h00);
      rst();
      wrt(8'h09, 8'h80);
      conv(8'h60, 10'h0C0);
      chk("masked", {7'h00, alarmOe}, 8'h00);
      $display("test pin modes done");
      rst();
      oneShot(8'h40, 1'b1);
      chk("standby", {7'h00, standbyMode}, 8'h01);
      oneShot(8'h00, 1'b0);
      rd(8'h0F);
      chk("one shot not kept", v, 8'h00);
      convBusy = 1'b1;
      rd(8'h02);
      chk("busy bit", v, 8'h80);
      convBusy = 1'b0;
      $display("test one shot done");
      give_verdict();
   end

endmodule : tb

`default_nettype wire
